// *** rtl/bbx_core.sv ***
// Execution unit for relative branches, bit operations and register copy
`timescale 1ns/100ps
`include "bbx_map.svh"
module bbx_core (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic op_valid_in,
    input wire bbx_pkg::bbx_op_t op_code_in,
    input wire logic [4:0] rd_sel_in,
    input wire logic [4:0] rr_sel_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic [`BBX_IO_AW-1:0] io_addr_in,
    input wire logic [6:0] offset_in,
    input wire logic [7:0] io_rdata_in,
    input wire logic [4:0] view_sel_in,
    output logic [`BBX_PC_W-1:0] pc_out,
    output logic [7:0] flags_out,
    output logic busy_out,
    output logic done_out,
    output logic io_re_out,
    output logic io_we_out,
    output logic [`BBX_IO_AW-1:0] io_addr_out,
    output logic [7:0] io_wdata_out,
    output logic [7:0] view_data_out
);
    // ****************************************
    // Declarations
    // ****************************************
    bbx_pkg::bbx_state_t state;
    bbx_pkg::bbx_state_t next_state;
    logic [`BBX_PC_W-1:0] next_pc;
    logic [`BBX_PC_W-1:0] tgt;
    logic [`BBX_PC_W-1:0] next_tgt;
    logic [`BBX_PC_W-1:0] branch_target;
    logic [7:0] next_flags;
    logic next_busy;
    logic next_done;
    logic next_io_re;
    logic next_io_we;
    logic [`BBX_IO_AW-1:0] next_io_addr;
    logic [7:0] next_io_wdata;
    logic [7:0] next_view;
    logic io_set;
    logic next_io_set;
    logic [2:0] io_bit;
    logic [2:0] next_io_bit;
    logic accept;
    logic is_branch;
    logic cond;
    logic rf_we;
    logic [7:0] rf_wdata;
    logic [7:0] rd_data;
    logic [7:0] rr_data;
    logic [7:0] view_data;
    logic [7:0] sh_res;
    logic sh_c;
    logic sh_z;
    logic sh_n;
    logic sh_v;

    // ****************************************
    // Submodules
    // ****************************************
    bbx_regfile u_regfile (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .we_in(rf_we),
        .wsel_in(rd_sel_in),
        .wdata_in(rf_wdata),
        .asel_in(rd_sel_in),
        .bsel_in(rr_sel_in),
        .csel_in(view_sel_in),
        .adata_out(rd_data),
        .bdata_out(rr_data),
        .cdata_out(view_data)
    );

    bbx_shift u_shift (
        .op_in(op_code_in),
        .data_in(rd_data),
        .carry_in(flags_out[`BBX_F_C]),
        .res_out(sh_res),
        .c_out(sh_c),
        .z_out(sh_z),
        .n_out(sh_n),
        .v_out(sh_v)
    );

    // ****************************************
    // Branch condition
    // ****************************************
    assign accept = op_valid_in && (state == bbx_pkg::BBX_ST_IDLE);
    assign branch_target = pc_out + `BBX_PC_W'(signed'(offset_in)) + `BBX_PC_ONE;

    always_comb begin
        is_branch = 1'b1;
        cond = 1'b0;
        case (op_code_in)
            bbx_pkg::BBX_OP_BRANCH_NOT_EQUAL: cond = !flags_out[`BBX_F_Z];
            bbx_pkg::BBX_OP_BRANCH_CARRY_HIGH,
            bbx_pkg::BBX_OP_BRANCH_LOWER: cond = flags_out[`BBX_F_C];
            bbx_pkg::BBX_OP_BRANCH_CARRY_CLEAR,
            bbx_pkg::BBX_OP_BRANCH_SAME_OR_HIGHER: cond = !flags_out[`BBX_F_C];
            bbx_pkg::BBX_OP_BRANCH_NEGATIVE: cond = flags_out[`BBX_F_N];
            bbx_pkg::BBX_OP_BRANCH_POSITIVE: cond = !flags_out[`BBX_F_N];
            bbx_pkg::BBX_OP_BRANCH_SIGNED_GE: cond = !(flags_out[`BBX_F_N] ^ flags_out[`BBX_F_V]);
            bbx_pkg::BBX_OP_BRANCH_SIGNED_LT: cond = flags_out[`BBX_F_N] ^ flags_out[`BBX_F_V];
            bbx_pkg::BBX_OP_BRANCH_HALFCARRY_HIGH: cond = flags_out[`BBX_F_H];
            bbx_pkg::BBX_OP_BRANCH_HALFCARRY_LOW: cond = !flags_out[`BBX_F_H];
            bbx_pkg::BBX_OP_BRANCH_TRANSFER_HIGH: cond = flags_out[`BBX_F_T];
            bbx_pkg::BBX_OP_BRANCH_TRANSFER_LOW: cond = !flags_out[`BBX_F_T];
            bbx_pkg::BBX_OP_BRANCH_OVERFLOW_HIGH: cond = flags_out[`BBX_F_V];
            bbx_pkg::BBX_OP_BRANCH_OVERFLOW_LOW: cond = !flags_out[`BBX_F_V];
            bbx_pkg::BBX_OP_BRANCH_IRQ_ON: cond = flags_out[`BBX_F_I];
            bbx_pkg::BBX_OP_BRANCH_IRQ_OFF: cond = !flags_out[`BBX_F_I];
            default: is_branch = 1'b0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_state = state;
        next_pc = pc_out;
        next_tgt = tgt;
        next_flags = flags_out;
        next_busy = 1'b0;
        next_done = 1'b0;
        next_io_re = 1'b0;
        next_io_we = 1'b0;
        next_io_addr = io_addr_out;
        next_io_wdata = io_wdata_out;
        next_io_set = io_set;
        next_io_bit = io_bit;
        next_view = view_data;
        rf_we = 1'b0;
        rf_wdata = sh_res;
        case (state)
            bbx_pkg::BBX_ST_IDLE: begin
                if (accept) begin
                    next_pc = pc_out + `BBX_PC_ONE;
                    next_done = 1'b1;
                    if (is_branch) begin
                        // taken branch takes a second cycle
                        if (cond) begin
                            next_tgt = branch_target;
                            next_state = bbx_pkg::BBX_ST_BR_LOAD;
                            next_busy = 1'b1;
                            next_done = 1'b0;
                            next_pc = pc_out;
                        end
                    end else begin
                        case (op_code_in)
                            bbx_pkg::BBX_OP_IO_BIT_RAISE,
                            bbx_pkg::BBX_OP_IO_BIT_LOWER: begin
                                next_io_re = 1'b1;
                                next_io_addr = io_addr_in;
                                next_io_bit = bit_sel_in;
                                next_io_set = (op_code_in == bbx_pkg::BBX_OP_IO_BIT_RAISE);
                                next_state = bbx_pkg::BBX_ST_IO_WRITE;
                                next_busy = 1'b1;
                                next_done = 1'b0;
                                next_pc = pc_out;
                            end
                            bbx_pkg::BBX_OP_LOGIC_SHIFT_LEFT,
                            bbx_pkg::BBX_OP_LOGIC_SHIFT_RIGHT,
                            bbx_pkg::BBX_OP_ROTATE_RIGHT_CARRY,
                            bbx_pkg::BBX_OP_ARITH_SHIFT_RIGHT: begin
                                rf_we = 1'b1;
                                next_flags[`BBX_F_Z] = sh_z;
                                next_flags[`BBX_F_C] = sh_c;
                                next_flags[`BBX_F_N] = sh_n;
                                next_flags[`BBX_F_V] = sh_v;
                            end
                            bbx_pkg::BBX_OP_BIT_TO_FLAG: begin
                                next_flags[`BBX_F_T] = rr_data[bit_sel_in];
                            end
                            bbx_pkg::BBX_OP_FLAG_TO_BIT: begin
                                rf_we = 1'b1;
                                rf_wdata = rd_data;
                                rf_wdata[bit_sel_in] = flags_out[`BBX_F_T];
                            end
                            bbx_pkg::BBX_OP_FLAG_RAISE: begin
                                next_flags[bit_sel_in] = 1'b1;
                            end
                            bbx_pkg::BBX_OP_FLAG_LOWER: begin
                                next_flags[bit_sel_in] = 1'b0;
                            end
                            bbx_pkg::BBX_OP_INTERRUPTS_ON: begin
                                next_flags[`BBX_F_I] = 1'b1;
                            end
                            bbx_pkg::BBX_OP_INTERRUPTS_OFF: begin
                                next_flags[`BBX_F_I] = 1'b0;
                            end
                            bbx_pkg::BBX_OP_REGISTER_COPY: begin
                                rf_we = 1'b1;
                                rf_wdata = rr_data;
                            end
                            default: begin
                                next_done = 1'b1;
                            end
                        endcase
                    end
                end
            end
            bbx_pkg::BBX_ST_BR_LOAD: begin
                next_pc = tgt;
                next_done = 1'b1;
                next_state = bbx_pkg::BBX_ST_IDLE;
            end
            bbx_pkg::BBX_ST_IO_WRITE: begin
                next_io_wdata = io_rdata_in;
                next_io_wdata[io_bit] = io_set;
                next_io_we = 1'b1;
                next_pc = pc_out + `BBX_PC_ONE;
                next_done = 1'b1;
                next_state = bbx_pkg::BBX_ST_IDLE;
            end
            default: begin
                next_state = bbx_pkg::BBX_ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= bbx_pkg::BBX_ST_IDLE;
            pc_out <= `BBX_PC_RST;
            tgt <= `BBX_PC_RST;
            flags_out <= `BBX_FLAGS_RST;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            io_re_out <= 1'b0;
            io_we_out <= 1'b0;
            io_addr_out <= '0;
            io_wdata_out <= `BBX_BYTE_ZERO;
            io_set <= 1'b0;
            io_bit <= 3'h0;
            view_data_out <= `BBX_BYTE_ZERO;
        end else begin
            state <= next_state;
            pc_out <= next_pc;
            tgt <= next_tgt;
            flags_out <= next_flags;
            busy_out <= next_busy;
            done_out <= next_done;
            io_re_out <= next_io_re;
            io_we_out <= next_io_we;
            io_addr_out <= next_io_addr;
            io_wdata_out <= next_io_wdata;
            io_set <= next_io_set;
            io_bit <= next_io_bit;
            view_data_out <= next_view;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_taken;
        accept && is_branch && cond;
    endsequence
    sequence s_io_start;
        accept && (op_code_in == bbx_pkg::BBX_OP_IO_BIT_RAISE || op_code_in == bbx_pkg::BBX_OP_IO_BIT_LOWER);
    endsequence

    branch_target_load_a: assert property (s_taken |=> busy_out && !done_out ##1
        (pc_out == $past(branch_target, 2)) && done_out)
        else $error("taken branch target wrong");
    // not taken branch is one cycle
    branch_not_taken_a: assert property (accept && is_branch && !cond |=>
        done_out && !busy_out && pc_out == $past(pc_out) + `BBX_PC_ONE)
        else $error("untaken branch wrong");
    branch_flags_kept_a: assert property (accept && is_branch |=> $stable(flags_out))
        else $error("branch changed flags");
    io_bit_write_a: assert property (s_io_start |=> io_re_out && busy_out ##1
        io_we_out && (io_wdata_out[$past(bit_sel_in, 2)] == ($past(op_code_in, 2) ==
        bbx_pkg::BBX_OP_IO_BIT_RAISE)) && flags_out == $past(flags_out, 2))
        else $error("io bit write wrong");
    shift_left_carry_a: assert property (accept && op_code_in == bbx_pkg::BBX_OP_LOGIC_SHIFT_LEFT |=>
        flags_out[`BBX_F_C] == $past(rd_data[`BBX_MSB]) && flags_out[`BBX_F_S] == $past(flags_out[`BBX_F_S]))
        else $error("left shift carry wrong");
    rotate_carry_in_a: assert property (accept && op_code_in == bbx_pkg::BBX_OP_ROTATE_RIGHT_CARRY
        && rd_sel_in == view_sel_in |=> ##1
        view_data_out[`BBX_MSB] == $past(flags_out[`BBX_F_C], 2))
        else $error("rotate carry wrong");
    bit_to_flag_a: assert property (accept && op_code_in == bbx_pkg::BBX_OP_BIT_TO_FLAG |=>
        flags_out[`BBX_F_T] == $past(rr_data[bit_sel_in]) &&
        (flags_out | 8'h40) == ($past(flags_out) | 8'h40))
        else $error("transfer flag wrong");
    flag_raise_only_a: assert property (accept && op_code_in == bbx_pkg::BBX_OP_FLAG_RAISE |=>
        flags_out == ($past(flags_out) | (8'h01 << $past(bit_sel_in))))
        else $error("flag raise wrong");
    reg_copy_flags_a: assert property (accept && op_code_in == bbx_pkg::BBX_OP_REGISTER_COPY |=>
        $stable(flags_out) && done_out)
        else $error("copy changed flags");
endmodule : bbx_core

// *** rtl/bbx_map.svh ***
// Constants for the branch and bit operation execution unit
`ifndef BBX_MAP_SVH
`define BBX_MAP_SVH
// ****************************************
// Widths
// ****************************************
`define BBX_PC_W 12
`define BBX_REG_N 32
`define BBX_IO_AW 6
// ****************************************
// Reset values and constants
// ****************************************
`define BBX_PC_RST 12'h000
`define BBX_PC_ONE 12'h001
`define BBX_FLAGS_RST 8'h00
`define BBX_BYTE_ZERO 8'h00
`define BBX_MSB 7
// ****************************************
// Status flag positions
// ****************************************
`define BBX_F_C 0
`define BBX_F_Z 1
`define BBX_F_N 2
`define BBX_F_V 3
`define BBX_F_S 4
`define BBX_F_H 5
`define BBX_F_T 6
`define BBX_F_I 7
`endif

// *** rtl/bbx_pkg.sv ***
// Types for the branch and bit operation execution unit
package bbx_pkg;
    typedef enum logic [5:0] {
        BBX_OP_NOP = 6'h00,
        BBX_OP_BRANCH_NOT_EQUAL = 6'h01,
        BBX_OP_BRANCH_CARRY_HIGH = 6'h02,
        BBX_OP_BRANCH_CARRY_CLEAR = 6'h03,
        BBX_OP_BRANCH_SAME_OR_HIGHER = 6'h04,
        BBX_OP_BRANCH_LOWER = 6'h05,
        BBX_OP_BRANCH_NEGATIVE = 6'h06,
        BBX_OP_BRANCH_POSITIVE = 6'h07,
        BBX_OP_BRANCH_SIGNED_GE = 6'h08,
        BBX_OP_BRANCH_SIGNED_LT = 6'h09,
        BBX_OP_BRANCH_HALFCARRY_HIGH = 6'h0A,
        BBX_OP_BRANCH_HALFCARRY_LOW = 6'h0B,
        BBX_OP_BRANCH_TRANSFER_HIGH = 6'h0C,
        BBX_OP_BRANCH_TRANSFER_LOW = 6'h0D,
        BBX_OP_BRANCH_OVERFLOW_HIGH = 6'h0E,
        BBX_OP_BRANCH_OVERFLOW_LOW = 6'h0F,
        BBX_OP_BRANCH_IRQ_ON = 6'h10,
        BBX_OP_BRANCH_IRQ_OFF = 6'h11,
        BBX_OP_IO_BIT_RAISE = 6'h12,
        BBX_OP_IO_BIT_LOWER = 6'h13,
        BBX_OP_LOGIC_SHIFT_LEFT = 6'h14,
        BBX_OP_LOGIC_SHIFT_RIGHT = 6'h15,
        BBX_OP_ROTATE_RIGHT_CARRY = 6'h16,
        BBX_OP_ARITH_SHIFT_RIGHT = 6'h17,
        BBX_OP_BIT_TO_FLAG = 6'h18,
        BBX_OP_FLAG_TO_BIT = 6'h19,
        BBX_OP_FLAG_RAISE = 6'h1A,
        BBX_OP_FLAG_LOWER = 6'h1B,
        BBX_OP_INTERRUPTS_ON = 6'h1C,
        BBX_OP_INTERRUPTS_OFF = 6'h1D,
        BBX_OP_REGISTER_COPY = 6'h1E
    } bbx_op_t;

    typedef enum logic [1:0] {
        BBX_ST_IDLE = 2'h0,
        BBX_ST_BR_LOAD = 2'h1,
        BBX_ST_IO_WRITE = 2'h2
    } bbx_state_t;
endpackage : bbx_pkg

// *** rtl/bbx_regfile.sv ***
// Working register file, 32 entries of 8 bits, three read ports
`timescale 1ns/100ps
`include "bbx_map.svh"
module bbx_regfile (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic we_in,
    input wire logic [4:0] wsel_in,
    input wire logic [7:0] wdata_in,
    input wire logic [4:0] asel_in,
    input wire logic [4:0] bsel_in,
    input wire logic [4:0] csel_in,
    output logic [7:0] adata_out,
    output logic [7:0] bdata_out,
    output logic [7:0] cdata_out
);
    logic [7:0] mem [`BBX_REG_N];
    logic [7:0] next_mem [`BBX_REG_N];

    assign adata_out = mem[asel_in];
    assign bdata_out = mem[bsel_in];
    assign cdata_out = mem[csel_in];

    for (genvar g = 0; g < `BBX_REG_N; g++) begin : g_ent
        always_comb begin
            next_mem[g] = mem[g];
            if (we_in && (wsel_in == 5'(g))) begin
                next_mem[g] = wdata_in;
            end
        end
        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                mem[g] <= `BBX_BYTE_ZERO;
            end else begin
                mem[g] <= next_mem[g];
            end
        end
    end
endmodule : bbx_regfile

// *** rtl/bbx_shift.sv ***
// Single bit shifts and rotate with their status results
`timescale 1ns/100ps
`include "bbx_map.svh"
module bbx_shift (
    input wire bbx_pkg::bbx_op_t op_in,
    input wire logic [7:0] data_in,
    input wire logic carry_in,
    output logic [7:0] res_out,
    output logic c_out,
    output logic z_out,
    output logic n_out,
    output logic v_out
);
    always_comb begin
        res_out = data_in;
        c_out = data_in[0];
        case (op_in)
            bbx_pkg::BBX_OP_LOGIC_SHIFT_LEFT: begin
                res_out = {data_in[6:0], 1'b0};
                c_out = data_in[`BBX_MSB];
            end
            bbx_pkg::BBX_OP_LOGIC_SHIFT_RIGHT: begin
                res_out = {1'b0, data_in[7:1]};
            end
            bbx_pkg::BBX_OP_ROTATE_RIGHT_CARRY: begin
                res_out = {carry_in, data_in[7:1]};
            end
            bbx_pkg::BBX_OP_ARITH_SHIFT_RIGHT: begin
                res_out = {data_in[`BBX_MSB], data_in[7:1]};
            end
            default: begin
                res_out = data_in;
            end
        endcase
        z_out = (res_out == `BBX_BYTE_ZERO);
        n_out = res_out[`BBX_MSB];
        v_out = n_out ^ c_out;
    end
endmodule : bbx_shift

// *** tb/testbench.sv ***
// Self-checking bench for the branch and bit operation execution unit
`timescale 1ns/100ps
`include "bbx_map.svh"
module testbench;
    logic clk_in, sys_rst_in, op_valid_in;
    bbx_pkg::bbx_op_t op_code_in;
    logic [4:0] rd_sel_in, rr_sel_in, view_sel_in;
    logic [2:0] bit_sel_in;
    logic [5:0] io_addr_in, io_addr_out;
    logic [6:0] offset_in;
    logic [7:0] io_rdata_in, flags_out, io_wdata_out, view_data_out;
    logic [11:0] pc_out;
    logic busy_out, done_out, io_re_out, io_we_out;
    logic [31:0] seed = 32'h0000B161;
    int n_mismatch = 0;
    int checked = 0;
    logic [11:0] m_pc;
    logic [7:0] m_f;
    logic [7:0] m_r [32];

    bbx_core bbx_core_i (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .op_valid_in(op_valid_in),
        .op_code_in(op_code_in),
        .rd_sel_in(rd_sel_in),
        .rr_sel_in(rr_sel_in),
        .bit_sel_in(bit_sel_in),
        .io_addr_in(io_addr_in),
        .offset_in(offset_in),
        .io_rdata_in(io_rdata_in),
        .view_sel_in(view_sel_in),
        .pc_out(pc_out),
        .flags_out(flags_out),
        .busy_out(busy_out),
        .done_out(done_out),
        .io_re_out(io_re_out),
        .io_we_out(io_we_out),
        .io_addr_out(io_addr_out),
        .io_wdata_out(io_wdata_out),
        .view_data_out(view_data_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic cmp_val(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_val

    task automatic cmp_cyc(string what, int exp, int got);
        checked++;
        if (got != exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_cyc

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // ****************************************
    // One instruction against the model
    // ****************************************
    task automatic run_op(int k);
        logic [7:0] d, res, wd;
        logic [17:0] cv;
        logic t, io, shf;
        int lat, n;
        {rd_sel_in, rr_sel_in, bit_sel_in, io_addr_in, offset_in, io_rdata_in} = 34'({rnd(), rnd()});
        view_sel_in = rd_sel_in;
        op_code_in = bbx_pkg::bbx_op_t'(k[5:0]);
        op_valid_in = 1'b1;
        d = m_r[rd_sel_in];
        res = d;
        io = (k == 18 || k == 19);
        shf = (k >= 20 && k <= 23);
        cv = {!m_f[7], m_f[7], !m_f[3], m_f[3], !m_f[6], m_f[6], !m_f[5], m_f[5], m_f[2] ^ m_f[3],
              !(m_f[2] ^ m_f[3]), !m_f[2], m_f[2], m_f[0], !m_f[0], !m_f[0], m_f[0], !m_f[1], 1'b0};
        t = (k <= 17) && cv[k];
        lat = (t || io) ? 2 : 1;
        if (t)
            m_pc = m_pc + {{5{offset_in[6]}}, offset_in};
        m_pc = m_pc + 12'h001;
        if (k == 20)
            res = {d[6:0], 1'b0};
        if (k == 21)
            res = {1'b0, d[7:1]};
        if (k == 22)
            res = {m_f[0], d[7:1]};
        if (k == 23)
            res = {d[7], d[7:1]};
        if (shf) begin
            m_f[0] = (k == 20) ? d[7] : d[0];
            m_f[1] = (res == 8'h00);
            m_f[2] = res[7];
            m_f[3] = res[7] ^ m_f[0];
        end
        if (k == 24)
            m_f[6] = m_r[rr_sel_in][bit_sel_in];
        if (k == 25)
            res[bit_sel_in] = m_f[6];
        if (k == 26 || k == 27)
            m_f[bit_sel_in] = (k == 26);
        if (k == 28 || k == 29)
            m_f[7] = (k == 28);
        if (k == 30)
            res = m_r[rr_sel_in];
        m_r[rd_sel_in] = res;
        wd = io_rdata_in;
        wd[bit_sel_in] = (k == 18);
        @(posedge clk_in);
        #1;
        op_valid_in = 1'b0;
        cmp_val("busy", lat == 2, busy_out);
        cmp_val("io_re", io, io_re_out);
        if (io)
            cmp_val("io_addr", io_addr_in, io_addr_out);
        n = 1;
        while (done_out !== 1'b1 && n < 8) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n == 8) begin
            n_mismatch++;
            end_of_test();
        end
        cmp_cyc("cycles", lat, n);
        cmp_val("pc", m_pc, pc_out);
        cmp_val("flags", m_f, flags_out);
        cmp_val("io_we", io, io_we_out);
        if (io)
            cmp_val("io_wdata", wd, io_wdata_out);
        @(posedge clk_in);
        #1;
        cmp_val("reg", m_r[view_sel_in], view_data_out);
    endtask : run_op

    initial begin
        sys_rst_in = 1'b1;
        op_valid_in = 1'b0;
        op_code_in = bbx_pkg::BBX_OP_NOP;
        {rd_sel_in, rr_sel_in, bit_sel_in, io_addr_in, offset_in, io_rdata_in, view_sel_in} = '0;
        m_pc = 12'h000;
        m_f = 8'h00;
        foreach (m_r[i])
            m_r[i] = 8'h00;
        repeat (12) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        cmp_val("pc", 12'h000, pc_out);
        cmp_val("flags", 8'h00, flags_out);
        for (int k = 0; k < 31; k++) begin
            repeat (4) run_op(k);
        end
        $display("test every_opcode done");
        // Reset in mid-run clears pc, flags and registers
        sys_rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        m_pc = 12'h000;
        m_f = 8'h00;
        foreach (m_r[i])
            m_r[i] = 8'h00;
        cmp_val("pc", m_pc, pc_out);
        cmp_val("flags", m_f, flags_out);
        $display("test mid_reset done");
        repeat (600) run_op(rnd() % 31);
        $display("test random_mix done");
        end_of_test();
    end
endmodule : testbench
